// ---- dck_params.svh ----
/*
 * Offsets, field positions, reset values and lookup constants for the DDR4
 * clock-enable and command front end (dck).
 * Assumes inclusion by the top module only.
 */
`ifndef DCK_PARAMS_SVH
`define DCK_PARAMS_SVH

`define DCK_ADDR_W        14
`define DCK_AXI_AW        8
`define DCK_OFS_CTRL      8'h00
`define DCK_OFS_STATUS    8'h04
`define DCK_OFS_CMDCNT    8'h08
`define DCK_CTRL_RESET    6'h00
`define DCK_CWL_RESET     5'h09
`define DCK_CTRL_CWL_LSB  0
`define DCK_CTRL_BL_LSB   3
`define DCK_CTRL_WL_BIT   5
`define DCK_ST_OPEN_LSB   8
`define DCK_ST_CWL_LSB    16
`define DCK_ST_ODT_BIT    21
`define DCK_CWL_TABLE     {5'h14, 5'h12, 5'h10, 5'h0E, 5'h0C, 5'h0B, 5'h0A, 5'h09}
`define DCK_RESP_OKAY     2'h0
`define DCK_RESP_SLVERR   2'h2

`endif

// ---- dck_pkg.sv ----
/*
 * Types shared by the clock-enable front end: power states, decoded
 * commands and burst modes.
 * Assumes dck_params.svh is on the include path.
 */
package dck_pkg;
    typedef enum logic [2:0] {
        DCK_RUN  = 3'h0,
        DCK_PPD  = 3'h1,
        DCK_APD  = 3'h2,
        DCK_SREF = 3'h3
    } dck_state_t;

    typedef enum logic [2:0] {
        DCK_C_NOP = 3'h0,
        DCK_C_ACT = 3'h1,
        DCK_C_RD  = 3'h2,
        DCK_C_WR  = 3'h3,
        DCK_C_PRE = 3'h4,
        DCK_C_REF = 3'h5,
        DCK_C_MRS = 3'h6,
        DCK_C_ZQ  = 3'h7
    } dck_cmd_t;

    typedef enum logic [1:0] {
        DCK_BL8 = 2'h0,
        DCK_OTF = 2'h1,
        DCK_BC4 = 2'h2
    } dck_bl_t;
endpackage

// ---- dck_top.sv ----
/*
 * DDR4 device-side clock-enable and command front end: samples the pins,
 * tracks power-down and self-refresh, gates the input buffers, decodes
 * commands and keeps per-bank open state; AXI4-Lite register slave.
 * Assumes the pins come asynchronously from the controller and that clk
 * is much faster than the memory clock so every crossing is seen.
 */
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "dck_params.svh"

module dck_top #(
    parameter int AW = `DCK_ADDR_W
) (
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    input  wire logic                   ck_t,
    input  wire logic                   ck_c,
    input  wire logic                   cke,
    input  wire logic                   cs_n,
    input  wire logic                   act_n,
    input  wire logic                   ras_n,
    input  wire logic                   cas_n,
    input  wire logic                   we_n,
    input  wire logic                   odt,
    input  wire logic                   bg,
    input  wire logic [1:0]             ba,
    input  wire logic [AW-1:0]          addr,
    input  wire logic                   dqs_wl,
    output logic                        clk_run,
    output logic                        drv_en,
    output logic                        ibuf_ck_en,
    output logic                        ibuf_odt_en,
    output logic                        ibuf_cmd_en,
    output logic                        odt_term,
    output logic                        cmd_valid,
    output dck_pkg::dck_cmd_t           cmd_code,
    output logic [2:0]                  cmd_bank,
    output logic [AW-1:0]               cmd_addr,
    output logic                        cmd_bc4,
    output dck_pkg::dck_state_t         pwr_state,
    output logic [4:0]                  cwl_cycles,
    output logic [15:0]                 wl_dq,
    input  wire logic [`DCK_AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [`DCK_AXI_AW-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready
);
    import dck_pkg::*;

    // ****************************************************************
    // pin bundle and state
    // ****************************************************************
    localparam int PW    = AW + 9;
    localparam int P_BA  = AW;
    localparam int P_BG  = AW + 2;
    localparam int P_WE  = AW + 3;
    localparam int P_CAS = AW + 4;
    localparam int P_RAS = AW + 5;
    localparam int P_ACT = AW + 6;
    localparam int P_CS  = AW + 7;
    localparam int P_ODT = AW + 8;
    localparam int A10   = 10;
    localparam int A12   = 12;

    typedef struct packed {
        logic [1:0]             ck_m;
        logic [1:0]             ck_s;
        logic                   ck_prev;
        logic                   cke_m;
        logic                   cke_s;
        logic                   cke_edge;
        logic [PW-1:0]          pin_m;
        logic [PW-1:0]          pin_s;
        logic                   dqs_m;
        logic                   dqs_s;
        logic                   dqs_prev;
        dck_state_t             state;
        logic [7:0]             open;
        logic                   clk_run;
        logic                   drv_en;
        logic                   ibuf_ck_en;
        logic                   ibuf_odt_en;
        logic                   ibuf_cmd_en;
        logic                   odt_term;
        logic                   cmd_valid;
        dck_cmd_t               cmd_code;
        logic [2:0]             cmd_bank;
        logic [AW-1:0]          cmd_addr;
        logic                   cmd_bc4;
        logic [4:0]             cwl_cycles;
        logic [15:0]            wl_dq;
        logic [5:0]             ctrl;
        logic [15:0]            cmd_cnt;
        logic                   aw_hold;
        logic [`DCK_AXI_AW-1:0] aw_addr;
        logic                   w_hold;
        logic [31:0]            w_data;
        logic                   w_strb0;
        logic                   awready;
        logic                   wready;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   arready;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
    } dck_regs_t;

    dck_regs_t  s;
    dck_regs_t  next_s;
    logic       ck_edge;
    logic       cmd_take;
    dck_cmd_t   dec;
    logic [2:0] dec_bank;
    logic [7:0] open_nxt;

    function automatic logic [4:0] cwl_of(input logic [2:0] sel);
        logic [39:0] tbl;
        tbl = `DCK_CWL_TABLE;
        return tbl[sel*5 +: 5];
    endfunction

    // ****************************************************************
    // edge and command decode
    // ****************************************************************
    // crossing = true high, complement low; edge is its first cycle
    assign ck_edge  = s.ck_s[1] & ~s.ck_s[0] & ~s.ck_prev;
    assign dec_bank = {s.pin_s[P_BG], s.pin_s[P_BA+1 -: 2]};
    // running state and enable high at this edge and the last; cs low
    assign cmd_take = ck_edge && s.state == DCK_RUN && s.cke_s && s.cke_edge
                      && !s.pin_s[P_CS];

    always_comb begin
        logic [2:0] rcw;
        rcw = {s.pin_s[P_RAS], s.pin_s[P_CAS], s.pin_s[P_WE]};
        if (!s.pin_s[P_ACT]) begin
            dec = DCK_C_ACT;
        end else begin
            case (rcw)
                3'h0:    dec = DCK_C_MRS;
                3'h1:    dec = DCK_C_REF;
                3'h2:    dec = DCK_C_PRE;
                3'h4:    dec = DCK_C_WR;
                3'h5:    dec = DCK_C_RD;
                3'h6:    dec = DCK_C_ZQ;
                default: dec = DCK_C_NOP;
            endcase
        end
    end

    // ****************************************************************
    // per-bank open rows
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_bank
            logic hit;
            logic auto_pre;
            assign hit      = dec_bank == 3'(gi);
            // auto precharge closes the bank at once; timing is not modelled
            assign auto_pre = (dec == DCK_C_RD || dec == DCK_C_WR) && s.pin_s[A10];
            always_comb begin
                open_nxt[gi] = s.open[gi];
                if (cmd_take) begin
                    if (dec == DCK_C_ACT && hit) begin
                        open_nxt[gi] = 1'b1;
                    end else if (dec == DCK_C_PRE && (hit || s.pin_s[A10])) begin
                        open_nxt[gi] = 1'b0;
                    end else if (auto_pre && hit) begin
                        open_nxt[gi] = 1'b0;
                    end
                end
            end
        end
    endgenerate

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        logic       wr_ok;
        logic       sel_ok;
        dck_state_t st;
        next_s            = s;
        wr_ok             = 1'b0;
        sel_ok            = 1'b0;
        st                = s.state;
        next_s.ck_m       = {ck_t, ck_c};
        next_s.ck_s       = s.ck_m;
        next_s.ck_prev    = s.ck_s[1] & ~s.ck_s[0];
        next_s.cke_m      = cke;
        next_s.cke_s      = s.cke_m;
        next_s.pin_m      = {odt, cs_n, act_n, ras_n, cas_n, we_n, bg, ba, addr};
        next_s.pin_s      = s.pin_m;
        next_s.dqs_m      = dqs_wl;
        next_s.dqs_s      = s.dqs_m;
        next_s.dqs_prev   = s.dqs_s;
        next_s.cmd_valid  = 1'b0;
        next_s.open       = open_nxt;
        if (ck_edge && s.state != DCK_SREF) begin
            next_s.cke_edge = s.cke_s;
        end
        case (s.state)
            DCK_RUN: begin
                // enable falling at an edge picks the low-power state
                if (ck_edge && s.cke_edge && !s.cke_s) begin
                    if (dec == DCK_C_REF && !s.pin_s[P_CS] && s.open == 8'h00) begin
                        st = DCK_SREF;
                    end else if (s.open != 8'h00) begin
                        st = DCK_APD;
                    end else begin
                        st = DCK_PPD;
                    end
                end
            end
            DCK_PPD, DCK_APD: begin
                if (ck_edge && s.cke_s) begin
                    st = DCK_RUN;
                end
            end
            DCK_SREF: begin
                // no clock edge needed: the clock may be stopped here
                if (s.cke_s) begin
                    st = DCK_RUN;
                    next_s.cke_edge = 1'b1;
                end
            end
            default: st = DCK_RUN;
        endcase
        next_s.state       = st;
        next_s.clk_run     = st == DCK_RUN;
        next_s.drv_en      = st == DCK_RUN;
        next_s.ibuf_cmd_en = st == DCK_RUN;
        next_s.ibuf_ck_en  = st != DCK_SREF;
        next_s.ibuf_odt_en = st != DCK_SREF;
        if (ck_edge && s.ibuf_odt_en) begin
            next_s.odt_term = s.pin_s[P_ODT];
        end else if (st == DCK_SREF) begin
            next_s.odt_term = 1'b0;
        end
        if (cmd_take) begin
            next_s.cmd_valid = 1'b1;
            next_s.cmd_code  = dec;
            next_s.cmd_bank  = dec_bank;
            next_s.cmd_addr  = s.pin_s[AW-1:0];
            next_s.cmd_cnt   = s.cmd_cnt + 16'h0001;
            case (dck_bl_t'(s.ctrl[`DCK_CTRL_BL_LSB +: 2]))
                DCK_BL8: next_s.cmd_bc4 = 1'b0;
                DCK_BC4: next_s.cmd_bc4 = 1'b1;
                DCK_OTF: next_s.cmd_bc4 = !s.pin_s[A12];
                default: next_s.cmd_bc4 = 1'b0;
            endcase
        end
        // leveling: clock level at the strobe rise, copied to every bit
        if (s.ctrl[`DCK_CTRL_WL_BIT] && s.dqs_s && !s.dqs_prev) begin
            next_s.wl_dq = {16{s.ck_s[1]}};
        end else if (!s.ctrl[`DCK_CTRL_WL_BIT]) begin
            next_s.wl_dq = 16'h0000;
        end

        // AXI4-Lite write: address and data taken in either order
        if (s.awready && s_axi_awvalid) begin
            next_s.aw_hold = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
            next_s.awready = 1'b0;
        end
        if (s.wready && s_axi_wvalid) begin
            next_s.w_hold  = 1'b1;
            next_s.w_data  = s_axi_wdata;
            next_s.w_strb0 = s_axi_wstrb[0];
            next_s.wready  = 1'b0;
        end
        if (s.aw_hold && s.w_hold && !s.bvalid) begin
            next_s.aw_hold = 1'b0;
            next_s.w_hold  = 1'b0;
            next_s.bvalid  = 1'b1;
            wr_ok = {s.aw_addr[`DCK_AXI_AW-1:2], 2'h0} == `DCK_OFS_CTRL
                 || {s.aw_addr[`DCK_AXI_AW-1:2], 2'h0} == `DCK_OFS_STATUS
                 || {s.aw_addr[`DCK_AXI_AW-1:2], 2'h0} == `DCK_OFS_CMDCNT;
            next_s.bresp = wr_ok ? `DCK_RESP_OKAY : `DCK_RESP_SLVERR;
            sel_ok = {s.aw_addr[`DCK_AXI_AW-1:2], 2'h0} == `DCK_OFS_CTRL;
            if (sel_ok && s.w_strb0) begin
                next_s.ctrl = s.w_data[5:0];
            end
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid  = 1'b0;
            next_s.awready = 1'b1;
            next_s.wready  = 1'b1;
        end
        next_s.cwl_cycles = cwl_of(next_s.ctrl[`DCK_CTRL_CWL_LSB +: 3]);

        // AXI4-Lite read: one outstanding, registered data
        if (s.arready && s_axi_arvalid) begin
            next_s.arready = 1'b0;
            next_s.rvalid  = 1'b1;
            next_s.rresp   = `DCK_RESP_OKAY;
            next_s.rdata   = 32'h0000_0000;
            case (s_axi_araddr)
                `DCK_OFS_CTRL:   next_s.rdata[5:0] = s.ctrl;
                `DCK_OFS_STATUS: begin
                    next_s.rdata[2:0] = s.state;
                    next_s.rdata[`DCK_ST_OPEN_LSB +: 8] = s.open;
                    next_s.rdata[`DCK_ST_CWL_LSB +: 5] = s.cwl_cycles;
                    next_s.rdata[`DCK_ST_ODT_BIT] = s.odt_term;
                end
                `DCK_OFS_CMDCNT: next_s.rdata[15:0] = s.cmd_cnt;
                default:         next_s.rresp = `DCK_RESP_SLVERR;
            endcase
        end
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid  = 1'b0;
            next_s.arready = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s             <= '0;
            s.state       <= DCK_RUN;
            s.ctrl        <= `DCK_CTRL_RESET;
            s.cwl_cycles  <= `DCK_CWL_RESET;
            s.clk_run     <= 1'b1;
            s.drv_en      <= 1'b1;
            s.ibuf_ck_en  <= 1'b1;
            s.ibuf_odt_en <= 1'b1;
            s.ibuf_cmd_en <= 1'b1;
            s.awready     <= 1'b1;
            s.wready      <= 1'b1;
            s.arready     <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign clk_run       = s.clk_run;
    assign drv_en        = s.drv_en;
    assign ibuf_ck_en    = s.ibuf_ck_en;
    assign ibuf_odt_en   = s.ibuf_odt_en;
    assign ibuf_cmd_en   = s.ibuf_cmd_en;
    assign odt_term      = s.odt_term;
    assign cmd_valid     = s.cmd_valid;
    assign cmd_code      = s.cmd_code;
    assign cmd_bank      = s.cmd_bank;
    assign cmd_addr      = s.cmd_addr;
    assign cmd_bc4       = s.cmd_bc4;
    assign pwr_state     = s.state;
    assign cwl_cycles    = s.cwl_cycles;
    assign wl_dq         = s.wl_dq;
    assign s_axi_awready = s.awready;
    assign s_axi_wready  = s.wready;
    assign s_axi_bvalid  = s.bvalid;
    assign s_axi_bresp   = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid  = s.rvalid;
    assign s_axi_rdata   = s.rdata;
    assign s_axi_rresp   = s.rresp;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_cmd_on_edge: assert property (cmd_valid |-> $past(ck_edge))
        else $error("command captured off a clock crossing");
    a_run_outputs: assert property (
        (pwr_state != DCK_RUN) |-> !clk_run && !drv_en && !ibuf_cmd_en)
        else $error("internal clocks or drivers on while enable low");
    a_apd_entry: assert property (
        (cmd_take == 1'b0 && ck_edge && s.state == DCK_RUN && s.cke_edge && !s.cke_s
         && dec != DCK_C_REF && s.open != 8'h00) |=> pwr_state == DCK_APD)
        else $error("open row did not lead to active power-down");
    a_pd_sync: assert property (
        (pwr_state inside {DCK_PPD, DCK_APD} && $past(pwr_state) == DCK_RUN)
        |-> $past(ck_edge))
        else $error("power-down entered without a clock edge");
    a_sref_exit: assert property (
        (pwr_state == DCK_SREF && s.cke_s) |=> pwr_state == DCK_RUN ##1 clk_run)
        else $error("self-refresh exit not taken on enable high");
    a_pd_buffers: assert property (
        pwr_state inside {DCK_PPD, DCK_APD} |-> ibuf_ck_en && ibuf_odt_en
        && !ibuf_cmd_en)
        else $error("power-down buffer gating wrong");
    a_sref_buffers: assert property (
        pwr_state == DCK_SREF |-> !ibuf_ck_en && !ibuf_odt_en && !ibuf_cmd_en)
        else $error("self-refresh buffer gating wrong");
    a_cwl_legal: assert property (
        cwl_cycles inside {5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0E, 5'h10, 5'h12, 5'h14})
        else $error("write latency outside the supported set");
    a_burst_mode: assert property (
        (cmd_valid && s.ctrl[`DCK_CTRL_BL_LSB +: 2] == 2'h2) |-> cmd_bc4)
        else $error("fixed chop mode produced an eight burst");
    a_wl_parallel: assert property (wl_dq == 16'h0000 || wl_dq == 16'hFFFF)
        else $error("leveling feedback not on all bits");
    a_cs_masks: assert property (cmd_valid |-> !$past(s.pin_s[P_CS]))
        else $error("command accepted with chip select high");

    c_sref: cover property (pwr_state == DCK_RUN ##1 pwr_state == DCK_SREF);
    c_apd: cover property (pwr_state == DCK_RUN ##1 pwr_state == DCK_APD);
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_bc4_otf: cover property (cmd_valid && cmd_bc4);
endmodule

// ---- dck_ctrl_model.sv ----
/* controller model: memory clock, clock enable and command pins.
   assumes one bench process calls its tasks, never two at once. */
`timescale 1ns/1ps
module dck_ctrl_model (
    input  wire logic   clk,
    output logic        ck_t,
    output logic        ck_c,
    output logic        cke,
    output logic        cs_n,
    output logic        act_n,
    output logic        ras_n,
    output logic        cas_n,
    output logic        we_n,
    output logic        odt,
    output logic        bg,
    output logic [1:0]  ba,
    output logic [13:0] addr
);
    // controller latency and refresh budget; counts are 4 ns bench clocks
    localparam bit RD_DBI  = 1'b0;
    localparam int CL_MIN  = RD_DBI ? 26 : 22;
    localparam int CL_PROG = CL_MIN + 2;
    localparam int RFC_CLK = 65;
    initial begin
        {ck_t, ck_c, cke, cs_n, act_n, ras_n, cas_n, we_n, odt} = 9'h0BE;
        {bg, ba, addr} = 17'h00000;
    end
    // one memory clock; p = {cs_n, act_n, ras_n, cas_n, we_n}
    task automatic cyc(input logic [4:0] p, input logic k, input logic [2:0] b,
                       input logic [13:0] a);
        @(posedge clk);
        ck_t <= 1'b0;
        ck_c <= 1'b1;
        cke <= k;
        odt <= k;
        {cs_n, act_n, ras_n, cas_n, we_n} <= p;
        {bg, ba} <= b;
        addr <= a;
        repeat (4) @(posedge clk);
        ck_t <= 1'b1;
        ck_c <= 1'b0;
        repeat (6) @(posedge clk);
        cs_n <= 1'b1;
        addr <= ~a; // deselected lines must not keep the old value
    endtask
    // enable rises with the memory clock parked
    task automatic wake();
        @(posedge clk);
        cke <= 1'b1;
    endtask
    // refresh, then stay off the pins for the 260 ns refresh cycle time
    task automatic refresh();
        cyc(5'h09, 1'b1, 3'h0, 14'h0000);
        repeat (RFC_CLK) @(posedge clk);
    endtask
endmodule

// ---- dck_top_bench.sv ----
/* self-checking bench for dck_top: axi register tasks and pin scenarios.
   assumes dck_ctrl_model drives all memory pins except dqs_wl, which the bench drives. */
`timescale 1ns/1ps
module dck_top_bench;
    import dck_pkg::*;
    logic        clk, arst_n, dqs_wl, ck_t, ck_c, cke, cs_n, act_n, ras_n, cas_n, we_n, odt, bg;
    logic [1:0]  ba, s_axi_bresp, s_axi_rresp;
    logic [13:0] addr, cmd_addr;
    logic        clk_run, drv_en, ibuf_ck_en, ibuf_odt_en, ibuf_cmd_en, odt_term, cmd_valid;
    logic        cmd_bc4, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready;
    dck_cmd_t    cmd_code;
    dck_state_t  pwr_state;
    logic [2:0]  cmd_bank;
    logic [4:0]  cwl_cycles;
    logic [15:0] wl_dq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    int          fail_count, n_checks, seen, i;
    logic [4:0]  tbl [8] = '{5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0E, 5'h10, 5'h12, 5'h14};

    dck_top dut (.clk, .arst_n, .ck_t, .ck_c, .cke, .cs_n, .act_n, .ras_n, .cas_n, .we_n,
        .odt, .bg, .ba, .addr, .dqs_wl, .clk_run, .drv_en, .ibuf_ck_en, .ibuf_odt_en,
        .ibuf_cmd_en, .odt_term, .cmd_valid, .cmd_code, .cmd_bank, .cmd_addr, .cmd_bc4,
        .pwr_state, .cwl_cycles, .wl_dq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    dck_ctrl_model m (.clk, .ck_t, .ck_c, .cke, .cs_n, .act_n, .ras_n, .cas_n, .we_n,
        .odt, .bg, .ba, .addr);

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) if (cmd_valid === 1'b1) seen <= seen + 1;

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s exp %h got %h", n, exp, got);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (i = 0; i <= 50; i++) begin
            @(posedge clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        if (i > 50) fail_count++;
        if (i > 50) print_verdict();
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(s_axi_bresp), 32'(r));
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (i = 0; i <= 50; i++) begin
            @(posedge clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        if (i > 50) fail_count++;
        if (i > 50) print_verdict();
        s_axi_rready <= 1'b0;
        chk("rdata", s_axi_rdata, e);
        chk("rresp", 32'(s_axi_rresp), 32'(r));
    endtask
    task automatic pins(input dck_state_t s, input logic [4:0] en);
        chk("state", 32'(pwr_state), 32'(s));
        chk("enables", 32'({clk_run, drv_en, ibuf_ck_en, ibuf_odt_en, ibuf_cmd_en}), 32'(en));
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs();
        axr(8'h00, 32'h0, 2'h0);
        for (int k = 0; k < 8; k++) begin
            axw(8'h00, 32'(k), 2'h0);
            chk("cwl", 32'(cwl_cycles), 32'(tbl[k]));
        end
        axr(8'h0C, 32'h0, 2'h2);
        axw(8'h40, 32'h1, 2'h2);
        $display("test regs done");
    endtask
    task automatic t_cmd();
        m.cyc(5'h0F, 1'b1, 3'h0, 14'h0000);
        m.cyc(5'h07, 1'b1, 3'h5, 14'h0123);
        chk("code", 32'(cmd_code), 32'(DCK_C_ACT));
        chk("bank", 32'(cmd_bank), 32'h5);
        chk("addr", 32'(cmd_addr), 32'h0123);
        m.cyc(5'h1D, 1'b1, 3'h5, 14'h0000);
        chk("count", seen, 32'h1);
        for (int k = 0; k < 3; k++) begin
            axw(8'h00, 32'(k << 3), 2'h0);
            m.cyc(5'h0D, 1'b1, 3'h5, 14'h1000);
            chk("chop", 32'(cmd_bc4), 32'(k == 2));
        end
        axw(8'h00, 32'h08, 2'h0);
        m.cyc(5'h0C, 1'b1, 3'h5, 14'h0000);
        chk("chop", 32'(cmd_bc4), 32'h1);
        $display("test commands done");
    endtask
    task automatic t_pd();
        m.cyc(5'h0F, 1'b0, 3'h0, 14'h0000);
        pins(DCK_APD, 5'h06);
        m.cyc(5'h07, 1'b0, 3'h1, 14'h0000);
        chk("count", seen, 32'h5);
        m.cyc(5'h0F, 1'b1, 3'h0, 14'h0000);
        pins(DCK_RUN, 5'h1F);
        m.cyc(5'h0A, 1'b1, 3'h0, 14'h0400);
        m.refresh();
        chk("ref", 32'(cmd_code), 32'(DCK_C_REF));
        m.cyc(5'h08, 1'b1, 3'h0, 14'(m.CL_PROG));
        chk("mrs", 32'(cmd_code), 32'(DCK_C_MRS));
        chk("mrs addr", 32'(cmd_addr), 32'(m.CL_PROG));
        m.cyc(5'h0E, 1'b1, 3'h0, 14'h0000);
        chk("zq", 32'(cmd_code), 32'(DCK_C_ZQ));
        axr(8'h08, 32'h9, 2'h0);
        m.cyc(5'h0F, 1'b0, 3'h0, 14'h0000);
        pins(DCK_PPD, 5'h06);
        m.cyc(5'h0F, 1'b1, 3'h0, 14'h0000);
        $display("test power-down done");
    endtask
    task automatic t_sr();
        m.cyc(5'h09, 1'b0, 3'h0, 14'h0000);
        pins(DCK_SREF, 5'h00);
        chk("odt", 32'(odt_term), 32'h0);
        m.wake();
        repeat (5) @(posedge clk);
        pins(DCK_RUN, 5'h1F);
        axw(8'h00, 32'h20, 2'h0);
        dqs_wl <= 1'b1;
        repeat (5) @(posedge clk);
        chk("level", 32'(wl_dq), 32'hFFFF);
        dqs_wl <= 1'b0;
        $display("test self-refresh done");
    endtask

    initial begin
        {arst_n, dqs_wl, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
        {s_axi_wdata, s_axi_wstrb} = 36'hF;
        {fail_count, n_checks, seen} = 96'h0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        t_regs();
        t_cmd();
        t_pd();
        t_sr();
        print_verdict();
    end
endmodule
